// File: hw/touch_key_scan_controller.sv
// touch key measurement unit: register file, manual and automatic scan
`timescale 1ns/1ps
module touch_key_scan_controller
  import touch_key_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   reset_n_in,
  // register port
  input  wire sfr_req_t               sfr_req_in,
  output logic [7:0]                  sfr_rdata_out,
  // control bits held outside the mapped registers
  input  wire logic                   auto_scan_select_in,
  input  wire logic [3:0]             touch_channel_sel_in,
  input  wire logic                   touch_convert_start_set_in,
  input  wire logic                   touch_convert_start_clr_in,
  input  wire logic                   auto_interval_long_in,
  input  wire logic [3:0][9:0]        auto_touch_threshold_in,
  input  wire logic                   isr_entry_in,
  input  wire logic [3:0]             adc_low_nibble_in,
  input  wire logic                   slow_clk_level_in,
  // status
  output logic                        touch_convert_start_out,
  output logic                        touch_irq_flag_out,
  // analog front end
  output afe_req_t                    afe_req_out,
  input  wire afe_rsp_t               afe_rsp_in
);

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  function automatic logic sfr_hit(input logic       strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
    sfr_hit = strobe && (addr == target);
  endfunction : sfr_hit

  ctrl_state_t st_q;
  ctrl_state_t st_d;
  logic [9:0]  cnt_value;
  logic        cnt_ovf;
  logic        manual_mode;
  logic        auto_mode;
  logic        slow_edge;
  logic [12:0] interval_last;
  logic        irq_set;
  logic        irq_clr;
  logic        wr_flags;
  logic [3:0]  below_thr;

  assign manual_mode   = !auto_scan_select_in && !st_q.pd;
  assign auto_mode     = auto_scan_select_in && st_q.pd;
  assign slow_edge     = slow_clk_level_in && !st_q.slow_q;
  assign interval_last = (auto_interval_long_in ? INTERVAL_LONG : INTERVAL_SHORT) - 13'h0001;
  assign wr_flags      = sfr_hit(sfr_req_in.wr, sfr_req_in.addr, ADDR_IRQ_FLAGS);

  // -------------------------------------------------------------------------
  // per-channel threshold compare
  // -------------------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_AUTO_CH; i++) begin : g_thr
      assign below_thr[i] = cnt_value < auto_touch_threshold_in[i];
    end
  endgenerate

  touch_pulse_counter u_counter (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .clear_in   (st_q.cnt_clear),
    .enable_in  (st_q.afe.start),
    .pulse_in   (afe_rsp_in.pulse),
    .count_out  (cnt_value),
    .ovf_out    (cnt_ovf)
  );

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.cnt_clear = 1'b0;
    st_d.slow_q    = slow_clk_level_in;
    irq_set        = 1'b0;
    irq_clr        = 1'b0;

    // control register write
    if (sfr_hit(sfr_req_in.wr, sfr_req_in.addr, ADDR_CONTROL)) begin
      st_d.pd  = sfr_req_in.wdata[BIT_POWER_DOWN];
      st_d.tmr = sfr_req_in.wdata[2:0];
    end

    // writing the flag bit as zero (DFh) clears the touch flag
    if (wr_flags && !sfr_req_in.wdata[BIT_IRQ_FLAG]) begin
      irq_clr = 1'b1;
    end
    if (auto_mode && isr_entry_in) begin
      irq_clr = 1'b1;
    end

    // start bit may be cleared by software at any time except in the cycle a manual launch sets it
    if (touch_convert_start_clr_in) begin
      st_d.start = 1'b0;
    end

    // the interval keeps running through each scan so that scans stay evenly spaced
    if (!auto_mode) begin
      st_d.interval_cnt = '0;
    end else if (slow_edge) begin
      if (st_q.interval_cnt >= interval_last) begin
        st_d.interval_cnt = '0;
      end else begin
        st_d.interval_cnt = st_q.interval_cnt + 13'h0001;
      end
    end

    case (st_q.fsm)
      S_IDLE: begin
        st_d.afe.start = 1'b0;
        if (manual_mode && touch_convert_start_set_in) begin
          st_d.fsm          = S_MANUAL;
          st_d.start        = 1'b1;
          st_d.done         = 1'b0;
          st_d.cnt_clear    = 1'b1;
          st_d.afe.start    = 1'b1;
          st_d.afe.channel  = touch_channel_sel_in;
          st_d.afe.ref_cap  = (touch_channel_sel_in == REF_CAP_CHANNEL);
          st_d.afe.time_sel = st_q.tmr;
          irq_clr           = 1'b1;
        end else if (auto_mode && slow_edge && st_q.interval_cnt >= interval_last) begin
          st_d.auto_ch = '0;
          st_d.fsm     = S_AUTO_GAP;
        end
      end

      S_MANUAL: begin
        if (!manual_mode) begin
          st_d.fsm       = S_IDLE;
          st_d.afe.start = 1'b0;
        end else if (afe_rsp_in.conv_end) begin
          st_d.fsm       = S_IDLE;
          st_d.afe.start = 1'b0;
          st_d.start     = 1'b0;
          st_d.done      = 1'b1;
          st_d.count     = cnt_value;
          st_d.ovf       = cnt_ovf;
          irq_set        = 1'b1;
        end
      end

      S_AUTO_GAP: begin
        if (!auto_mode) begin
          st_d.fsm = S_IDLE;
        end else begin
          st_d.fsm          = S_AUTO_MEAS;
          st_d.cnt_clear    = 1'b1;
          st_d.afe.start    = 1'b1;
          st_d.afe.channel  = {2'b00, st_q.auto_ch};
          st_d.afe.ref_cap  = 1'b0;
          st_d.afe.time_sel = st_q.tmr;
        end
      end

      S_AUTO_MEAS: begin
        if (!auto_mode) begin
          st_d.fsm       = S_IDLE;
          st_d.afe.start = 1'b0;
        end else if (afe_rsp_in.conv_end) begin
          st_d.afe.start = 1'b0;
          st_d.count     = cnt_value;
          st_d.ovf       = cnt_ovf;
          st_d.done      = 1'b1;
          if (below_thr[st_q.auto_ch]) begin
            irq_set = 1'b1;
          end
          if (st_q.auto_ch == LAST_AUTO_CH) begin
            st_d.fsm = S_IDLE;
          end else begin
            st_d.auto_ch = st_q.auto_ch + 2'h1;
            st_d.fsm     = S_AUTO_GAP;
          end
        end
      end

      default: begin
        st_d.fsm       = S_IDLE;
        st_d.afe.start = 1'b0;
      end
    endcase

    // a set in the same cycle as a clear wins
    if (irq_set) begin
      st_d.irq = 1'b1;
    end else if (irq_clr) begin
      st_d.irq = 1'b0;
    end

    // registered read data
    st_d.rdata = 8'h00;
    if (sfr_req_in.rd) begin
      case (sfr_req_in.addr)
        ADDR_IRQ_FLAGS: st_d.rdata[BIT_IRQ_FLAG] = st_q.irq;
        ADDR_CONV_DATA: st_d.rdata = {adc_low_nibble_in, st_q.done, st_q.ovf, st_q.count[9:8]};
        ADDR_COUNT_LOW: st_d.rdata = st_q.count[7:0];
        ADDR_CONTROL:   st_d.rdata = {st_q.pd, 4'h0, st_q.tmr};
        default:        st_d.rdata = 8'h00;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q      <= '0;
      st_q.fsm  <= S_IDLE;
      st_q.pd   <= PD_RESET;
      st_q.tmr  <= TMR_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata_out           = st_q.rdata;
  assign touch_convert_start_out = st_q.start;
  assign touch_irq_flag_out      = st_q.irq;
  assign afe_req_out             = st_q.afe;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_start_auto_clear: assert property (
    (st_q.fsm == S_MANUAL && manual_mode && afe_rsp_in.conv_end) |=> !st_q.start && st_q.done)
    else $error("start bit not cleared at conversion end");

  chk_done_while_busy: assert property (
    (st_q.fsm == S_MANUAL) |-> !st_q.done)
    else $error("done flag high during conversion");

  chk_auto_needs_mode: assert property (
    (st_q.fsm == S_AUTO_MEAS) |-> $past(auto_mode) && !$past(manual_mode))
    else $error("automatic scan outside automatic mode");

  chk_irq_manual_end: assert property (
    (st_q.fsm == S_MANUAL && manual_mode && afe_rsp_in.conv_end) |=> st_q.irq)
    else $error("touch flag not set at manual conversion end");

  chk_irq_isr_clear: assert property (
    (auto_mode && isr_entry_in && st_q.fsm == S_IDLE) |=> !st_q.irq)
    else $error("touch flag not cleared on service entry");

  chk_auto_ch_range: assert property (
    (st_q.afe.start && st_q.fsm == S_AUTO_MEAS) |-> st_q.afe.channel < 4'h4 && !st_q.afe.ref_cap)
    else $error("automatic scan left channels 0 to 3");

  chk_ref_cap_select: assert property (
    (st_q.fsm == S_IDLE && manual_mode && touch_convert_start_set_in
      && touch_channel_sel_in == REF_CAP_CHANNEL) |=> st_q.afe.ref_cap && st_q.afe.start)
    else $error("reference capacitor not selected for channel 15");

  chk_count_low_read: assert property (
    (sfr_req_in.rd && sfr_req_in.addr == ADDR_COUNT_LOW) |=> sfr_rdata_out == $past(st_q.count[7:0]))
    else $error("count low byte read mismatch");

  chk_ovf_read: assert property (
    (sfr_req_in.rd && sfr_req_in.addr == ADDR_CONV_DATA) |=> sfr_rdata_out[BIT_COUNT_OVF] == $past(st_q.ovf))
    else $error("overflow bit read mismatch");

  chk_scan_interval: assert property (
    (st_q.fsm == S_IDLE && auto_mode && slow_edge && st_q.interval_cnt >= interval_last)
      |=> st_q.fsm == S_AUTO_GAP ##1 st_q.afe.start && st_q.afe.channel == 4'h0)
    else $error("scan not started at interval end");

  chk_start_sw_clear: assert property (
    (touch_convert_start_clr_in
      && !(st_q.fsm == S_IDLE && manual_mode && touch_convert_start_set_in)) |=> !st_q.start)
    else $error("start bit not cleared by software");

  chk_flag_write_clear: assert property (
    (wr_flags && !sfr_req_in.wdata[BIT_IRQ_FLAG] && !irq_set) |=> !st_q.irq)
    else $error("touch flag not cleared by flag register write");

  chk_touch_irq_auto: assert property (
    (st_q.fsm == S_AUTO_MEAS && auto_mode && afe_rsp_in.conv_end && below_thr[st_q.auto_ch]) |=> st_q.irq)
    else $error("touch below threshold raised no flag");

  chk_pd_write: assert property (
    (sfr_req_in.wr && sfr_req_in.addr == ADDR_CONTROL) |=> st_q.pd == $past(sfr_req_in.wdata[BIT_POWER_DOWN]))
    else $error("power down bit not written");

  chk_launch_setup: assert property (
    (st_q.fsm == S_IDLE && manual_mode && touch_convert_start_set_in)
      |=> st_q.afe.time_sel == $past(st_q.tmr) && st_q.afe.channel == $past(touch_channel_sel_in))
    else $error("front end setup differs from control settings");

  chk_count_latch: assert property (
    (st_q.fsm == S_MANUAL && manual_mode && afe_rsp_in.conv_end)
      |=> st_q.count == $past(cnt_value) && st_q.ovf == $past(cnt_ovf))
    else $error("count not latched at conversion end");

  chk_adc_nibble_read: assert property (
    (sfr_req_in.rd && sfr_req_in.addr == ADDR_CONV_DATA)
      |=> sfr_rdata_out[7:4] == $past(adc_low_nibble_in) && sfr_rdata_out[BIT_CONV_DONE] == $past(st_q.done))
    else $error("shared data register read mismatch");

endmodule : touch_key_scan_controller

// File: hw/touch_key_pkg.sv
// constants, types and state layout for the touch key scan controller
package touch_key_pkg;

  // -------------------------------------------------------------------------
  // register offsets and fields
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h95;
  localparam logic [7:0] ADDR_CONV_DATA   = 8'hAA;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hAC;
  localparam logic [7:0] ADDR_CONTROL     = 8'hAD;
  localparam int         BIT_IRQ_FLAG     = 5;
  localparam int         BIT_CONV_DONE    = 3;
  localparam int         BIT_COUNT_OVF    = 2;
  localparam int         BIT_POWER_DOWN   = 7;
  localparam logic       PD_RESET         = 1'b1;
  localparam logic [2:0] TMR_RESET        = 3'h4;

  // -------------------------------------------------------------------------
  // channels, counts and scan timing
  // -------------------------------------------------------------------------
  localparam int          NUM_CHANNELS    = 14;
  localparam int          NUM_AUTO_CH     = 4;
  localparam int          COUNT_W         = 10;
  localparam logic [3:0]  REF_CAP_CHANNEL = 4'hF;
  localparam logic [9:0]  COUNT_MAX       = 10'h3FF;
  localparam logic [12:0] INTERVAL_SHORT  = 13'h0800;
  localparam logic [12:0] INTERVAL_LONG   = 13'h1000;
  localparam logic [1:0]  LAST_AUTO_CH    = 2'h3;

  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic       start;
    logic       ref_cap;
    logic [3:0] channel;
    logic [2:0] time_sel;
  } afe_req_t;

  typedef struct packed {
    logic pulse;
    logic conv_end;
  } afe_rsp_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_MANUAL,
    S_AUTO_MEAS,
    S_AUTO_GAP
  } scan_state_t;

  typedef struct packed {
    logic [9:0] count;
    logic       ovf;
  } counter_state_t;

  typedef struct packed {
    scan_state_t fsm;
    logic        start;
    logic        done;
    logic        ovf;
    logic [9:0]  count;
    logic        irq;
    logic        pd;
    logic [2:0]  tmr;
    logic [7:0]  rdata;
    logic [1:0]  auto_ch;
    logic [12:0] interval_cnt;
    logic        slow_q;
    logic        cnt_clear;
    afe_req_t    afe;
  } ctrl_state_t;

endpackage : touch_key_pkg

// File: hw/touch_pulse_counter.sv
// ten-bit charge pulse counter with sticky overflow
`timescale 1ns/1ps
module touch_pulse_counter
  import touch_key_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  // control
  input  wire logic       clear_in,
  input  wire logic       enable_in,
  input  wire logic       pulse_in,
  // result
  output logic [9:0]      count_out,
  output logic            ovf_out
);

  counter_state_t st_q;
  counter_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (clear_in) begin
      st_d = '0;
    end else if (enable_in && pulse_in) begin
      if (st_q.count == COUNT_MAX) begin
        st_d.ovf = 1'b1;
      end else begin
        st_d.count = st_q.count + 10'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_out = st_q.count;
  assign ovf_out   = st_q.ovf;

endmodule : touch_pulse_counter

// File: verif/touch_electrode_model.sv
// behavioural electrode and charge capacitor: charge pulses then end of conversion
`timescale 1ns/1ps
module touch_electrode_model
  import touch_key_pkg::*;
(
  // clock
  input  wire logic              sys_clk_in,
  // pulse totals per channel, slow charging
  input  wire logic [15:0][10:0] total_in,
  input  wire logic              slow_in,
  // front end
  input  wire afe_req_t          afe_req_in,
  output afe_rsp_t               afe_rsp_out = '0
);
  int   left = -1;
  logic tog  = 1'b0;

  // slow charging gives one pulse every other cycle
  always @(posedge sys_clk_in) begin
    afe_rsp_out <= '0;
    tog         <= ~tog;
    if (!afe_req_in.start) begin
      left <= -1;
    end else if (left == -1) begin
      left <= int'(total_in[afe_req_in.channel]);
    end else if (left == 0) begin
      afe_rsp_out.conv_end <= 1'b1;
      left                 <= -2;
    end else if (left > 0 && (!slow_in || tog)) begin
      afe_rsp_out.pulse <= 1'b1;
      left              <= left - 1;
    end
  end
endmodule : touch_electrode_model

// File: verif/test_touch_key_scan_controller.sv
// self-checking bench for the touch key scan controller
`timescale 1ns/1ps
module test_touch_key_scan_controller;
  import touch_key_pkg::*;
  logic              sys_clk  = 1'b0;
  logic              reset_n  = 1'b0;
  sfr_req_t          req      = '0;
  logic              auto_sel = 1'b0;
  logic              set_s    = 1'b0;
  logic              clr_s    = 1'b0;
  logic              ilong    = 1'b0;
  logic              isr      = 1'b0;
  logic              slow     = 1'b0;
  logic              mslow    = 1'b0;
  logic              prev     = 1'b0;
  logic [3:0]        ch_sel   = 4'h0;
  logic [3:0]        adc      = 4'h0;
  logic [3:0][9:0]   thr      = '0;
  logic [15:0][10:0] tot      = '0;
  logic [7:0]        rdata;
  logic [7:0]        d;
  logic              start_o;
  logic              irq;
  afe_req_t          afe_req;
  afe_rsp_t          afe_rsp;
  int                n_mismatch = 0;
  int                n_tests    = 0;
  int                cyc        = 0;
  int                st_t[$];
  logic [3:0]        st_ch[$];

  always #5 sys_clk = ~sys_clk;

  // slow clock level and log of every measurement launch
  always @(posedge sys_clk) begin
    cyc  <= cyc + 1;
    slow <= ~slow;
    prev <= afe_req.start;
    if (afe_req.start && !prev) begin
      st_t.push_back(cyc);
      st_ch.push_back(afe_req.channel);
    end
  end

  touch_key_scan_controller dut (
    .sys_clk_in                 (sys_clk),
    .reset_n_in                 (reset_n),
    .sfr_req_in                 (req),
    .sfr_rdata_out              (rdata),
    .auto_scan_select_in        (auto_sel),
    .touch_channel_sel_in       (ch_sel),
    .touch_convert_start_set_in (set_s),
    .touch_convert_start_clr_in (clr_s),
    .auto_interval_long_in      (ilong),
    .auto_touch_threshold_in    (thr),
    .isr_entry_in               (isr),
    .adc_low_nibble_in          (adc),
    .slow_clk_level_in          (slow),
    .touch_convert_start_out    (start_o),
    .touch_irq_flag_out         (irq),
    .afe_req_out                (afe_req),
    .afe_rsp_in                 (afe_rsp)
  );

  touch_electrode_model model (
    .sys_clk_in  (sys_clk),
    .total_in    (tot),
    .slow_in     (mslow),
    .afe_req_in  (afe_req),
    .afe_rsp_out (afe_rsp)
  );

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    req <= '{wr: wr, rd: !wr, addr: a, wdata: w};
    @(posedge sys_clk);
    req <= '0;
    #1 d = rdata;
  endtask : sfr

  task automatic strobe_start();
    @(posedge sys_clk);
    set_s <= 1'b1;
    @(posedge sys_clk);
    set_s <= 1'b0;
    #1;
  endtask : strobe_start

  // waits for the measurement to end, bounded
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (afe_req.start !== 1'b0 && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= lim) begin
      n_mismatch++;
      close_out();
    end else begin
      repeat (2) @(posedge sys_clk);
      #1;
    end
  endtask : wait_idle

  task automatic wait_starts(input int n);
    int k;
    k = 0;
    while (st_t.size() < n && k < 20000) begin
      @(posedge sys_clk);
      k++;
    end
    wait_idle(1000);
  endtask : wait_starts

  task automatic manual(input logic [3:0] c, input int n, input logic [2:0] tm);
    logic [9:0] e;
    e      = (n > 1023) ? 10'h3FF : n[9:0];
    tot[c] = n[10:0];
    mslow  = 1'($urandom_range(1));
    @(posedge sys_clk);
    ch_sel <= c;
    adc    <= 4'($urandom);
    sfr(1'b1, ADDR_CONTROL, {5'h00, tm});
    strobe_start();
    chk("start bit", 16'h1, start_o);
    chk("flag at start", 16'h0, irq);
    chk("front end", {1'b1, c == 4'hF, c, tm}, afe_req);
    sfr(1'b0, ADDR_CONV_DATA, 8'h00);
    chk("done running", 16'h0, d[3]);
    wait_idle(3000);
    chk("start cleared", 16'h0, start_o);
    chk("flag at end", 16'h1, irq);
    sfr(1'b0, ADDR_CONV_DATA, 8'h00);
    chk("data reg", {adc, 1'b1, n > 1023, e[9:8]}, d);
    sfr(1'b0, ADDR_COUNT_LOW, 8'h00);
    chk("count low", e[7:0], d);
    repeat (5000) @(posedge sys_clk);
  endtask : manual

  // ---------------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'hF8ED4E10));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    sfr(1'b0, ADDR_CONTROL, 8'h00);
    chk("control reset", 16'h84, d);
    sfr(1'b0, ADDR_IRQ_FLAGS, 8'h00);
    chk("flags reset", 16'h00, d);
    sfr(1'b0, 8'h00, 8'h00);
    chk("unmapped", 16'h00, d);
    sfr(1'b1, ADDR_CONTROL, 8'hFB);
    sfr(1'b0, ADDR_CONTROL, 8'h00);
    chk("control rw", 16'h83, d);
    for (int i = 0; i < 8; i++) begin
      manual(i == 2 ? 4'hF : 4'($urandom_range(13)),
             i == 0 ? 1023 : i == 1 ? 1024 : int'($urandom_range(900, 20)), 3'(i));
    end
    // software clears the start bit itself; the conversion still completes
    strobe_start();
    @(posedge sys_clk);
    clr_s <= 1'b1;
    @(posedge sys_clk);
    clr_s <= 1'b0;
    #1 chk("start cleared by software", 16'h0, start_o);
    chk("conversion kept", 16'h1, afe_req.start);
    wait_idle(3000);
    chk("flag after software clear", 16'h1, irq);
    sfr(1'b1, ADDR_IRQ_FLAGS, 8'hFF);
    chk("flag kept", 16'h1, irq);
    sfr(1'b1, ADDR_IRQ_FLAGS, 8'hDF);
    chk("flag cleared", 16'h0, irq);
    @(posedge sys_clk);
    auto_sel <= 1'b1;
    strobe_start();
    repeat (2) @(posedge sys_clk);
    chk("no start", 16'h0, afe_req.start);
    // equal counts are not a touch
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      tot[i] = 11'($urandom_range(200, 100));
      thr[i] <= tot[i][9:0];
    end
    mslow = 1'b0;
    st_t.delete();
    st_ch.delete();
    sfr(1'b1, ADDR_CONTROL, 8'h80);
    wait_starts(8);
    for (int i = 0; i < 8; i++) begin
      chk("scan channel", 16'(i % 4), st_ch[i]);
    end
    chk("short interval", 16'd4096, 16'(st_t[4] - st_t[0]));
    chk("no touch", 16'h0, irq);
    @(posedge sys_clk);
    thr[2] <= tot[2][9:0] + 10'h001;
    wait_starts(12);
    chk("touch", 16'h1, irq);
    sfr(1'b0, ADDR_COUNT_LOW, 8'h00);
    chk("last count", tot[3][7:0], d);
    @(posedge sys_clk);
    isr <= 1'b1;
    @(posedge sys_clk);
    isr <= 1'b0;
    #1 chk("isr clear", 16'h0, irq);
    @(posedge sys_clk);
    ilong <= 1'b1;
    wait_starts(16);
    chk("long interval", 16'd8192, 16'(st_t[12] - st_t[8]));
    chk("touch again", 16'h1, irq);
    sfr(1'b1, ADDR_IRQ_FLAGS, 8'hDF);
    chk("write clear", 16'h0, irq);
    close_out();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
endmodule : test_touch_key_scan_controller
